// ---- verilog/spirap_core.sv ----
// Serial register access port: slave front end that turns serial frames
// into register reads and buffered register writes, plus its write FIFO.
// Assumes a register file on clk_sys that answers reads combinationally.
`timescale 1ns/10ps
`default_nettype none

module spirap_fifo #(
  parameter int WIDTH = spirap_pkg::WRBUF_WIDTH,
  parameter int DEPTH = spirap_pkg::WRBUF_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              full;
  wire              empty;
  wire              doPush;
  wire              doPop;

  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && !empty;
  assign inReady  = !full;
  assign outValid = !empty;
  assign doPush   = inValid && !full;
  assign doPop    = outReady && !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= doPush ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_q <= doPop ? rdPtr_q + 1'b1 : rdPtr_q;
    end
  end
endmodule

// Behaviour
// R1: Master opens each access with one command byte, then data bytes.
// R2: Command and data bytes travel most significant bit first both ways.
// R3: Command bits 7..3 pick register 0 to 31 as plain binary.
// R4: Direction bit 1 writes following bytes, 0 reads them.
// R5: Peripheral mode: set acknowledge flag sets stall register acknowledge bit.
// R6: Master sets acknowledge flag only after finishing a control transfer.
// R7: Host mode ignores the acknowledge flag entirely.
// R8: Full duplex: eight status bits go out during the command byte.
// R9: Half duplex: no status during command; status only via registers.
// R10: Registers 0 to 4 freeze the pointer for the whole frame.
// R11: Registers 5 to 19 advance the pointer by one per byte.
// R12: Pointer reaching register 20 stays there for the frame.
// R13: Registers 21 to 31 advance, holding at 31.
// R14: Registers without function in current mode read as zero.
// R15: Master avoids writing ones into unused bits.
// R16: Setting host bit of register 27 switches to host operation.
// R17: Peripheral mode offers 26 registers, host mode 23, same addressing.
// R18: Command: register bits 7..3, zero bit 2, direction 1, acknowledge 0.
// R19: Select low frames a transfer; high ignores clock, output undriven.
// R20: Sample input on rising clock edge, change output on falling.
// R21: Half duplex keeps serial output undriven; data line returns reads.
// R22: Pointer loads from each command byte; policy applies per frame.
module spirap_core #(
  parameter logic [31:0] HOST_REGS = spirap_pkg::HOST_USED_MASK,
  parameter int          FIFO_DEPTH = spirap_pkg::WRBUF_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       spiClk,
  input  wire logic       selectN,
  input  wire logic       mosiIn,
  output logic            mosiOut,
  output logic            mosiOeN,
  output logic            misoOut,
  output logic            misoOeN,
  input  wire logic [7:0] usbStatus,
  output logic      [4:0] rdAddr,
  input  wire logic [7:0] rdData,
  output logic            rdStrobe,
  output logic            wrValid,
  input  wire logic       wrReady,
  output logic      [4:0] wrAddr,
  output logic      [7:0] wrData,
  output logic            wrOverflow,
  output logic            ackStatSet,
  output logic            hostMode,
  output logic            fullDuplex
);
  logic                      sclkS1_q, sclkS2_q, sclkS3_q;
  logic                      selS1_q, selS2_q, selS3_q;
  logic                      mosiS1_q, mosiS2_q;
  spirap_pkg::spirap_state_t state_q;
  logic [2:0]                bitCnt_q;
  logic [7:0]                rxShift_q;
  logic [7:0]                txShift_q;
  logic [4:0]                ptr_q;
  logic                      dirWr_q;
  logic                      host_q;
  logic                      fdup_q;
  logic                      rdStb_q;
  logic                      ack_q;
  logic                      ovf_q;

  wire       selected;
  wire       ssFall;
  wire       ssRise;
  wire       sclkRise;
  wire       sclkFall;
  wire       byteDone;
  wire [7:0] rxByte;
  wire       cmdDone;
  wire       dataDone;
  wire       pushValid;
  wire       fifoInReady;
  wire       rdLoad;
  wire [31:0] usedMask;
  wire       regUsed;
  wire [7:0] rdMasked;
  wire [4:0] ptrNext;
  wire [12:0] fifoOut;
  wire [4:0] cmdAddr;
  wire       hostBitIn;

  function automatic logic [4:0] nextPtr(input logic [4:0] p);
    if (p <= spirap_pkg::REG_FIFO_LAST) begin
      nextPtr = p; // R10
    end else if (p == spirap_pkg::REG_FREEZE_MID) begin
      nextPtr = p; // R12
    end else if (p == spirap_pkg::REG_LAST) begin
      nextPtr = p; // R13
    end else begin
      nextPtr = p + 5'h01; // R11 R13
    end
  endfunction

  // Pin synchronisers; first stages feed only second stages
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {sclkS1_q, sclkS2_q, sclkS3_q} <= 3'h0;
      {selS1_q, selS2_q, selS3_q}    <= 3'h7;
      {mosiS1_q, mosiS2_q}           <= 2'h0;
    end else begin
      {sclkS1_q, sclkS2_q, sclkS3_q} <= {spiClk, sclkS1_q, sclkS2_q};
      {selS1_q, selS2_q, selS3_q}    <= {selectN, selS1_q, selS2_q};
      {mosiS1_q, mosiS2_q}           <= {mosiIn, mosiS1_q};
    end
  end

  assign selected  = !selS2_q;
  assign ssFall    = !selS2_q && selS3_q; // R19
  assign ssRise    = selS2_q && !selS3_q;
  assign sclkRise  = selected && !selS3_q && sclkS2_q && !sclkS3_q; // R19 R20
  assign sclkFall  = selected && !selS3_q && !sclkS2_q && sclkS3_q; // R20
  assign byteDone  = sclkRise && (bitCnt_q == 3'h7);
  assign rxByte    = {rxShift_q[6:0], mosiS2_q}; // R2
  assign cmdDone   = byteDone && (state_q == spirap_pkg::SPI_CMD); // R1
  assign dataDone  = byteDone && (state_q == spirap_pkg::SPI_DATA);
  assign pushValid = dataDone && dirWr_q; // R4
  assign rdLoad    = sclkFall && (bitCnt_q == 3'h0)
                     && (state_q == spirap_pkg::SPI_DATA) && !dirWr_q; // R4
  assign usedMask  = host_q ? HOST_REGS : spirap_pkg::PERIPH_USED_MASK; // R17
  assign regUsed   = usedMask[ptr_q];
  assign rdMasked  = regUsed ? rdData : spirap_pkg::RST_BYTE; // R14
  assign ptrNext   = nextPtr(ptr_q);
  assign cmdAddr   = rxByte[spirap_pkg::CMD_ADDR_MSB:spirap_pkg::CMD_ADDR_LSB]; // R3 R18
  assign hostBitIn = rxByte[spirap_pkg::MODE_HOST_BIT];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= spirap_pkg::SPI_IDLE;
    end else if (ssRise || !selected) begin
      state_q <= spirap_pkg::SPI_IDLE;
    end else if (ssFall) begin
      state_q <= spirap_pkg::SPI_CMD;
    end else if (cmdDone) begin
      state_q <= spirap_pkg::SPI_DATA;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_q  <= spirap_pkg::RST_BIT_COUNT;
      rxShift_q <= spirap_pkg::RST_BYTE;
    end else if (ssFall) begin
      bitCnt_q  <= spirap_pkg::RST_BIT_COUNT;
    end else if (sclkRise) begin
      bitCnt_q  <= bitCnt_q + 3'h1;
      rxShift_q <= rxByte; // R2 R20
    end
  end

  // Command byte loads the pointer; each data byte moves it by policy
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q   <= 5'h00;
      dirWr_q <= 1'b0;
    end else if (cmdDone) begin
      ptr_q   <= cmdAddr; // R3 R18 R22
      dirWr_q <= rxByte[spirap_pkg::CMD_DIR_BIT]; // R4 R18
    end else if (dataDone) begin
      ptr_q   <= ptrNext; // R10 R11 R12 R13
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txShift_q <= spirap_pkg::RST_BYTE;
    end else if (ssFall) begin
      txShift_q <= fdup_q ? usbStatus : spirap_pkg::RST_BYTE; // R8 R9
    end else if (rdLoad) begin
      txShift_q <= rdMasked; // R14
    end else if (sclkFall) begin
      txShift_q <= {txShift_q[6:0], 1'b0}; // R2 R20
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q   <= 1'b0;
      rdStb_q <= 1'b0;
    end else begin
      ack_q   <= cmdDone && rxByte[spirap_pkg::CMD_ACK_BIT] && !host_q; // R5 R7
      rdStb_q <= rdLoad;
    end
  end

  // Mode bits mirrored from writes so the port follows them at once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_q <= spirap_pkg::RST_HOST_MODE;
      fdup_q <= spirap_pkg::RST_FULL_DUPLEX;
    end else if (pushValid && ptr_q == spirap_pkg::REG_MODE) begin
      host_q <= hostBitIn; // R16
    end else if (pushValid && ptr_q == spirap_pkg::REG_PINCTL) begin
      fdup_q <= rxByte[spirap_pkg::PINCTL_FDUP_BIT];
    end
  end

  // Overflow stays until the next frame begins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovf_q <= 1'b0;
    end else if (pushValid && !fifoInReady) begin
      ovf_q <= 1'b1;
    end else if (ssFall) begin
      ovf_q <= 1'b0;
    end
  end

  spirap_fifo #(
    .WIDTH (spirap_pkg::WRBUF_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_wrbuf (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  (pushValid),
    .inReady  (fifoInReady),
    .inData   ({ptr_q, rxByte}),
    .outValid (wrValid),
    .outReady (wrReady),
    .outData  (fifoOut)
  );

  assign wrAddr     = fifoOut[12:8];
  assign wrData     = fifoOut[7:0];
  assign wrOverflow = ovf_q;
  assign rdAddr     = ptr_q;
  assign rdStrobe   = rdStb_q;
  assign ackStatSet = ack_q;
  assign hostMode   = host_q;
  assign fullDuplex = fdup_q;
  assign misoOut    = txShift_q[7];
  assign mosiOut    = txShift_q[7];
  assign misoOeN    = !(selected && fdup_q); // R19 R21
  assign mosiOeN    = !(selected && !fdup_q && !dirWr_q
                        && state_q == spirap_pkg::SPI_DATA); // R21

  AST_ADDR_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n) // R22
    cmdDone |=> ptr_q == $past(cmdAddr))
    else $error("pointer not loaded from command");
  AST_ACK_PERIPH: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
    (cmdDone && rxByte[0] && !host_q) |=> ackStatSet ##1 !ackStatSet)
    else $error("acknowledge pulse missing");
  AST_ACK_HOST: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
    (cmdDone && host_q) |=> !ackStatSet)
    else $error("acknowledge raised in host mode");
  AST_FIFO_FREEZE: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    (dataDone && ptr_q <= 5'h04) |=> $stable(ptr_q))
    else $error("fifo pointer moved");
  AST_INCR_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
    (dataDone && ptr_q >= 5'h05 && ptr_q <= 5'h13) |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("pointer did not advance");
  AST_HOLD_20: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
    (dataDone && ptr_q == 5'h14) |=> ptr_q == 5'h14)
    else $error("pointer left register 20");
  AST_HIGH_RANGE: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
    (dataDone && ptr_q >= 5'h15) |=> ptr_q == (($past(ptr_q) == 5'h1f) ? 5'h1f
                                              : $past(ptr_q) + 5'h01))
    else $error("pointer wrong above 20");
  AST_STATUS_FD: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
    (ssFall && fdup_q) |=> txShift_q == $past(usbStatus) && !misoOeN)
    else $error("status not presented");
  AST_STATUS_HD: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
    (ssFall && !fdup_q) |=> txShift_q == 8'h00 && misoOeN)
    else $error("status shifted in half duplex");
  AST_IDLE_HIZ: assert property (@(posedge clk_sys) disable iff (!reset_n) // R19
    !selected |-> misoOeN && mosiOeN && state_q == spirap_pkg::SPI_IDLE || ssRise)
    else $error("pins driven while deselected");
  AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    (rdLoad && !regUsed) |=> txShift_q == 8'h00 ##1 rdStrobe == 1'b0)
    else $error("unused register read nonzero");
  AST_HOST_SEL: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
    (pushValid && ptr_q == 5'h1b) |=> hostMode == $past(hostBitIn))
    else $error("host bit not taken");
  AST_HALF_MISO: assert property (@(posedge clk_sys) disable iff (!reset_n) // R21
    !fdup_q |-> misoOeN)
    else $error("serial output driven in half duplex");
endmodule
`default_nettype wire

// ---- verilog/spirap_pkg.sv ----
// Package for the serial register access port: command layout, address
// policy limits, register map facts and buffer sizes.
// Assumes a single 20 MHz system clock domain for all users.
`default_nettype none
package spirap_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BYTE_BITS     = 8;
  localparam int REG_NUM_BITS  = 5;

  // Command byte fields
  localparam int CMD_ADDR_MSB = 7;
  localparam int CMD_ADDR_LSB = 3;
  localparam int CMD_ZERO_BIT = 2;
  localparam int CMD_DIR_BIT  = 1;
  localparam int CMD_ACK_BIT  = 0;

  // Address pointer policy
  localparam logic [4:0] REG_FIFO_LAST  = 5'h04;
  localparam logic [4:0] REG_FREEZE_MID = 5'h14;
  localparam logic [4:0] REG_LAST       = 5'h1f;

  // Mode bits held locally so the port can follow them
  localparam logic [4:0] REG_PINCTL      = 5'h11;
  localparam int         PINCTL_FDUP_BIT = 4;
  localparam logic [4:0] REG_MODE        = 5'h1b;
  localparam int         MODE_HOST_BIT   = 0;

  // Registers with a function in each mode (bit n = register n)
  localparam logic [31:0] PERIPH_USED_MASK = 32'h09ff_ffff;
  localparam logic [31:0] HOST_USED_MASK   = 32'hffef_e01f;

  // Values after reset
  localparam logic       RST_FULL_DUPLEX = 1'b0;
  localparam logic       RST_HOST_MODE   = 1'b0;
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [2:0] RST_BIT_COUNT   = 3'h0;

  // Write buffer
  localparam int WRBUF_DEPTH = 32;
  localparam int WRBUF_WIDTH = REG_NUM_BITS + BYTE_BITS;

  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_CMD,
    SPI_DATA
  } spirap_state_t;
endpackage
`default_nettype wire

// ---- testbench/spirap_master.sv ----
// Serial master model for the register access port: frames, clocks and
// shares the data line. Assumes mode 0 clocking at a 400 ns link period.
`timescale 1ns/10ps
`default_nettype none
module spirap_master (
  output logic      spiClk,
  output logic      selectN,
  output wire logic mosiLine,
  input  wire logic mosiOut,
  input  wire logic mosiOeN,
  input  wire logic misoOut,
  input  wire logic misoOeN
);
  logic [7:0] txb [0:63];
  logic [7:0] rxb [0:64];
  logic       drvOn;
  logic       drvBit;
  logic       junk;
  logic       oeBad;
  initial begin
    spiClk = 1'b0;
    selectN = 1'b1;
    drvOn = 1'b0;
    drvBit = 1'b0;
    junk = 1'b0;
    oeBad = 1'b0;
  end
  // A released line shows a changing level, never the last bit
  always #50 junk = ~junk;
  assign mosiLine = !mosiOeN ? mosiOut : (drvOn ? drvBit : junk);
  // Command byte first, then data bytes, all MSB first
  task automatic frame(input logic [7:0] cmd, input int n, input logic fd, input logic rd);
    logic [7:0] b;
    oeBad = 1'b0;
    selectN = 1'b0;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? cmd : txb[k-1];
      drvOn = (k == 0) || fd || !rd;
      for (int i = 7; i >= 0; i--) begin
        drvBit = b[i];
        #200 if (misoOeN !== !fd) oeBad = 1'b1;
        spiClk = 1'b1;
        #190 rxb[k][i] = fd ? misoOut : mosiLine;
        #10 spiClk = 1'b0;
        drvOn = drvOn && !(k == 0 && i == 0 && rd && !fd);
      end
    end
    #200 selectN = 1'b1;
    drvOn = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the register access port, with a static
// register file model and a randomly stalling write consumer.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_sys, reset_n, mosiIn, spiClk, selectN, mosiOut, mosiOeN;
  logic        misoOut, misoOeN, rdStrobe, wrValid, wrReady, wrOverflow;
  logic        ackStatSet, hostMode, fullDuplex, stall, hostExp, fdExp;
  logic [7:0]  usbStatus, rdData, wrData;
  logic [4:0]  rdAddr, wrAddr;
  logic [7:0]  regs [0:31];
  logic [12:0] got [$];
  logic [12:0] want [$];
  int          bad_count, tests_run, ackCnt, n, rdCnt;
  integer      seed;
  spirap_master M (.spiClk(spiClk), .selectN(selectN), .mosiLine(mosiIn), .mosiOut(mosiOut),
    .mosiOeN(mosiOeN), .misoOut(misoOut), .misoOeN(misoOeN));
  spirap_core #(.FIFO_DEPTH(4)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .spiClk(spiClk),
    .selectN(selectN), .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoOut(misoOut), .misoOeN(misoOeN), .usbStatus(usbStatus), .rdAddr(rdAddr),
    .rdData(rdData), .rdStrobe(rdStrobe), .wrValid(wrValid), .wrReady(wrReady),
    .wrAddr(wrAddr), .wrData(wrData), .wrOverflow(wrOverflow), .ackStatSet(ackStatSet),
    .hostMode(hostMode), .fullDuplex(fullDuplex));
  always #25 clk_sys = ~clk_sys;
  assign rdData = regs[rdAddr];
  always @(posedge clk_sys) begin
    if (wrValid === 1'b1 && wrReady === 1'b1) got.push_back({wrAddr, wrData});
    if (ackStatSet === 1'b1) ackCnt++;
    if (rdStrobe === 1'b1) rdCnt++;
    wrReady <= #1 !stall && (($random(seed) & 1) != 0);
  end
  task automatic stop_test;
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chkB(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkF(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  function automatic logic [4:0] nxt(input logic [4:0] x);
    return (x <= spirap_pkg::REG_FIFO_LAST || x == spirap_pkg::REG_FREEZE_MID ||
      x == spirap_pkg::REG_LAST) ? x : x + 5'h01;
  endfunction
  function automatic logic [7:0] rexp(input logic [4:0] x);
    logic [31:0] m;
    m = hostExp ? spirap_pkg::HOST_USED_MASK : spirap_pkg::PERIPH_USED_MASK;
    return m[x] ? regs[x] : 8'h00;
  endfunction
  // One frame, then its read bytes and status are checked
  task automatic go(input logic [4:0] x, input logic wr, input logic ack, input int cnt);
    int r0;
    @(posedge clk_sys);
    #1 usbStatus = 8'($random(seed));
    r0 = rdCnt;
    M.frame({x, 1'b0, wr, ack}, cnt, fdExp, !wr);
    chkF(M.oeBad, 1'b0);
    chkB(8'(rdCnt - r0), wr ? 8'h00 : 8'(cnt + 1));
    if (fdExp) chkB(M.rxb[0], usbStatus);
    for (int k = 0; k < cnt; k++) begin
      if (wr) want.push_back({x, M.txb[k]});
      else chkB(M.rxb[k+1], rexp(x));
      x = nxt(x);
    end
  endtask
  task automatic drain;
    logic [12:0] g, w;
    int t;
    t = 0;
    while (got.size() < want.size() && t < 2000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t == 2000) begin
      bad_count++;
      $display("ERROR %0t write buffer timeout", $time);
      stop_test;
    end
    while (want.size() > 0) begin
      g = got.pop_front();
      w = want.pop_front();
      chkB(g[7:0], w[7:0]);
      chkB({3'h0, g[12:8]}, {3'h0, w[12:8]});
    end
  endtask
  task automatic fill;
    for (int i = 0; i < 8; i++) M.txb[i] = 8'($random(seed));
  endtask
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    stall = 1'b0;
    usbStatus = 8'h00;
    hostExp = 1'b0;
    fdExp = 1'b0;
    bad_count = 0;
    tests_run = 0;
    ackCnt = 0;
    rdCnt = 0;
    seed = 32'h4aa0ed4d;
    for (int i = 0; i < 32; i++) regs[i] = 8'($random(seed));
    repeat (20) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chkF(misoOeN, 1'b1);
    chkF(mosiOeN, 1'b1);
    chkF(hostMode, 1'b0);
    chkF(wrValid, 1'b0);
    repeat (3) @(posedge clk_sys);
    go(5'h03, 1'b0, 1'b0, 3);
    go(5'h12, 1'b0, 1'b0, 4);
    M.txb[0] = 8'h10;
    go(spirap_pkg::REG_PINCTL, 1'b1, 1'b0, 1);
    fdExp = 1'b1;
    drain;
    chkF(fullDuplex, 1'b1);
    go(5'h1e, 1'b0, 1'b0, 3);
    go(5'h19, 1'b0, 1'b0, 2);
    repeat (6) go(5'($random(seed)), 1'b0, 1'b0, ($random(seed) & 3) + 1);
    fill;
    go(5'h15, 1'b1, 1'b0, 4);
    fill;
    go(5'h13, 1'b1, 1'b0, 3);
    drain;
    n = ackCnt;
    go(5'h00, 1'b0, 1'b1, 0);
    chkB(8'(ackCnt - n), 8'h01);
    M.txb[0] = 8'h01;
    go(spirap_pkg::REG_MODE, 1'b1, 1'b0, 1);
    hostExp = 1'b1;
    drain;
    chkF(hostMode, 1'b1);
    n = ackCnt;
    go(5'h00, 1'b1, 1'b1, 0);
    chkB(8'(ackCnt - n), 8'h00);
    go(5'h05, 1'b0, 1'b0, 4);
    stall = 1'b1;
    fill;
    go(5'h00, 1'b1, 1'b0, 6);
    chkF(wrOverflow, 1'b1);
    void'(want.pop_back());
    void'(want.pop_back());
    stall = 1'b0;
    drain;
    go(5'h02, 1'b1, 1'b0, 1);
    chkF(wrOverflow, 1'b0);
    drain;
    stop_test;
  end
endmodule
`default_nettype wire
